// file: emb_params.svh
// Timing and reset constants for the external memory bus port controller.
// Assumes one core clock that also serves as the oscillator reference.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH

// Machine cycle of twelve oscillator periods, two halves of six
`define EMB_PHASE_LAST   4'hB
`define EMB_HALF_PHASE   4'h6
`define EMB_PHASE_ZERO   4'h0
// Phases within a half cycle
`define EMB_ALE_LAST     4'h1
`define EMB_ADDR_LAST    4'h2
`define EMB_PROGRAM_STORE_STROBE_FIRST   4'h3
// Phases within a data move cycle
`define EMB_STRB_FIRST   4'h3
`define EMB_STRB_LAST    4'hA
`define EMB_RD_SAMPLE    4'hB
// Highest internal program address
`define EMB_INT_TOP      16'h0FFF
// Byte values and reset values
`define EMB_BYTE_ONES    8'hFF
`define EMB_BYTE_ZERO    8'h00
`define EMB_ADDR_RST     16'h0000

`endif

// file: emb_pkg.sv
// Types shared by the external memory bus port controller.
// Assumes emb_params.svh is on the include path.
`default_nettype none
package emb_pkg;

    // One port's pin drive: output value and output enable per bit
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
    } emb_pin_t;

    // Four byte-wide ports
    typedef struct packed {
        logic [7:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } emb_ports_t;

    // External data move request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        ptr16;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } emb_xmove_t;

    // Alternate-function inputs taken from the special function port
    typedef struct packed {
        logic timer_b_input;
        logic timer_a_input;
        logic ext_interrupt_b;
        logic ext_interrupt_a;
        logic rxd;
    } emb_alt_t;

    // Kind of the current machine cycle
    typedef enum logic {
        KIND_FETCH,
        KIND_DATA
    } emb_kind_t;

endpackage
`default_nettype wire

// file: emb_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module emb_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = din;
        sync_d = meta_q;
    end

    // Stage registers, first stage read only by the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;

endmodule
`default_nettype wire

// file: emb_phase_gen.sv
// Machine cycle phase counter, twelve oscillator periods per cycle.
// Assumes hold is a synchronous level from the same clock.
`timescale 1ns/1ps
`default_nettype none

module emb_phase_gen
    import emb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       hold,
    output logic      [3:0] phase,
    output logic            cycle_start
);

`include "emb_params.svh"

    logic [3:0] phase_q;
    logic [3:0] phase_d;
    logic       start_q;
    logic       start_d;

    // Wrap at the last phase, park at zero while held
    always_comb begin
        if (hold || phase_q == `EMB_PHASE_LAST) begin
            phase_d = `EMB_PHASE_ZERO;
        end else begin
            phase_d = phase_q + 4'h1;
        end
        start_d = !hold && (phase_d == `EMB_PHASE_ZERO);
    end

    // Counter registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= `EMB_PHASE_ZERO;
            start_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            start_q <= start_d;
        end
    end

    assign phase       = phase_q;
    assign cycle_start = start_q;

endmodule
`default_nettype wire

// file: emb_port_ctrl.sv
// External memory bus and port pin controller of an 8-bit microcontroller.
// Assumes core-side inputs are on CORE_CLK; pin inputs are asynchronous.
// Behaviour
// - Muxed port is open-drain; pins written one float and act as inputs.
// - Bus cycles put low address then data on muxed port, ones driven hard.
// - General port is quasi-bidirectional; ones pulled high, usable as inputs.
// - High address port drives upper address for external fetch and wide moves.
// - Reset pin high puts the block into reset.
// - Address latch pulse marks the low address on the muxed port.
// - Address latch pulse repeats every six oscillator periods.
// - Each external data move drops exactly one address latch pulse.
// - External code fetch strobes program store twice per machine cycle.
// - Each external data move skips two program store strobes.
// - Internal code fetches never strobe program store.
// - Access select held low sends the lowest code addresses external.
// - Access select high fetches internally until address passes top internal.
// - Verify mode drives internal code bytes onto the muxed port.
// - Verify mode takes the low verify address from the general port.
// - Special port has pullups; ones pulled high, usable as inputs.
`timescale 1ns/1ps
`default_nettype none

module emb_port_ctrl
    import emb_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        NRST,
    input  wire logic [15:0] FETCH_ADDR,
    input  wire emb_xmove_t  XMOVE_REQ,
    input  wire emb_ports_t  PORT_LATCH,
    input  wire logic        SERIAL_TX,
    input  wire logic [7:0]  ROM_DATA,
    input  wire emb_ports_t  PORT_IN,
    input  wire logic        EXT_ACCESS_SELECT_N,
    input  wire logic        RST_PIN,
    input  wire logic        VERIFY_PIN,
    output emb_pin_t         P0,
    output emb_pin_t         P1,
    output emb_pin_t         P2,
    output emb_pin_t         P3,
    output logic             ADDR_LATCH_EN,
    output logic             PROGRAM_STORE_STROBE_N,
    output logic             CYCLE_START,
    output logic             FETCH_EXT,
    output logic [7:0]       CODE_BYTE,
    output logic             CODE_VALID,
    output logic [7:0]       DATA_RDATA,
    output logic             DATA_DONE,
    output emb_ports_t       PORT_PINS,
    output emb_alt_t         ALT_IN,
    output logic [7:0]       VERIFY_ADDR,
    output logic             VERIFY_ACTIVE,
    output logic             RESET_REQ
);

`include "emb_params.svh"

    // Synchronised pin inputs
    emb_ports_t pins_s;
    logic       ea_n_s;
    logic       rst_s;
    logic       vfy_s;
    logic [3:0] phase;
    logic [3:0] half_ph;

    emb_sync #(
        .W (35)
    ) u_sync (
        .clk  (CORE_CLK),
        .nrst (NRST),
        .din  ({PORT_IN, EXT_ACCESS_SELECT_N, RST_PIN, VERIFY_PIN}),
        .dout ({pins_s, ea_n_s, rst_s, vfy_s})
    );

    // Machine cycle timing, parked while the reset pin is high
    emb_phase_gen u_phase (
        .clk         (CORE_CLK),
        .nrst        (NRST),
        .hold        (rst_s),
        .phase       (phase),
        .cycle_start (CYCLE_START)
    );

    // Phase within the current half cycle
    assign half_ph = (phase < `EMB_HALF_PHASE) ? phase : (phase - `EMB_HALF_PHASE);

    // ---- Bus sequencing state ----
    emb_kind_t   kind_q;
    emb_kind_t   kind_d;
    logic        ext_q;
    logic        ext_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic [7:0]  wdata_q;
    logic [7:0]  wdata_d;
    logic        write_q;
    logic        write_d;
    logic        ptr16_q;
    logic        ptr16_d;
    logic        ext_now;

    // Pick cycle kind and half-cycle address at each boundary
    always_comb begin
        kind_d  = kind_q;
        ext_d   = ext_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        write_d = write_q;
        ptr16_d = ptr16_q;
        ext_now = !ea_n_s || (FETCH_ADDR > `EMB_INT_TOP);
        if (rst_s) begin
            kind_d = KIND_FETCH;
            ext_d  = 1'b0;
            addr_d = `EMB_ADDR_RST;
        end else if (phase == `EMB_PHASE_LAST) begin
            if (XMOVE_REQ.valid) begin
                kind_d  = KIND_DATA;
                ext_d   = 1'b1;
                addr_d  = XMOVE_REQ.addr;
                wdata_d = XMOVE_REQ.wdata;
                write_d = XMOVE_REQ.write;
                ptr16_d = XMOVE_REQ.ptr16;
            end else begin
                kind_d = KIND_FETCH;
                ext_d  = ext_now;
                addr_d = FETCH_ADDR;
            end
        end else if (phase == `EMB_HALF_PHASE - 4'h1 && kind_q == KIND_FETCH) begin
            ext_d  = ext_now;
            addr_d = FETCH_ADDR;
        end
    end

    // Sequencing registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            kind_q  <= KIND_FETCH;
            ext_q   <= 1'b0;
            addr_q  <= `EMB_ADDR_RST;
            wdata_q <= `EMB_BYTE_ZERO;
            write_q <= 1'b0;
            ptr16_q <= 1'b0;
        end else begin
            kind_q  <= kind_d;
            ext_q   <= ext_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            write_q <= write_d;
            ptr16_q <= ptr16_d;
        end
    end

    // ---- Pin drive state ----
    emb_pin_t p0_q;
    emb_pin_t p0_d;
    emb_pin_t p1_q;
    emb_pin_t p1_d;
    emb_pin_t p2_q;
    emb_pin_t p2_d;
    emb_pin_t p3_q;
    emb_pin_t p3_d;
    logic     ale_q;
    logic     ale_d;
    logic     program_store_strobe_n_q;
    logic     program_store_strobe_n_d;
    logic     fext_q;
    logic     fext_d;
    logic     ext_fetch;
    logic     strobe;
    logic     data_rd;
    logic     data_wr;
    logic [7:0] p3_val;

    // Strobes, address and data on the pins for the coming clock
    always_comb begin
        ext_fetch = (kind_q == KIND_FETCH) && ext_q;
        strobe    = (kind_q == KIND_DATA) && (phase >= `EMB_STRB_FIRST)
                    && (phase <= `EMB_STRB_LAST);
        data_rd   = strobe && !write_q;
        data_wr   = strobe && write_q;
        // Pulse every half cycle, second one dropped in a data move
        ale_d     = !rst_s && (half_ph <= `EMB_ALE_LAST)
                    && !(kind_q == KIND_DATA && phase >= `EMB_HALF_PHASE);
        // Read strobe only for external fetch, never in data moves
        program_store_strobe_n_d  = !(ext_fetch && !vfy_s && !rst_s
                    && (half_ph >= `EMB_PROGRAM_STORE_STROBE_FIRST));
        fext_d    = ext_fetch;
        // Muxed port
        if (rst_s) begin
            p0_d.dout = `EMB_BYTE_ZERO;
            p0_d.oe   = `EMB_BYTE_ZERO;
        end else if (vfy_s) begin
            p0_d.dout = ROM_DATA;
            p0_d.oe   = `EMB_BYTE_ONES;
        end else if ((ext_fetch && half_ph <= `EMB_ADDR_LAST)
                     || (kind_q == KIND_DATA && phase <= `EMB_ADDR_LAST)) begin
            p0_d.dout = addr_q[7:0];
            p0_d.oe   = `EMB_BYTE_ONES;
        end else if (data_wr) begin
            p0_d.dout = wdata_q;
            p0_d.oe   = `EMB_BYTE_ONES;
        end else if (ext_fetch || kind_q == KIND_DATA) begin
            p0_d.dout = `EMB_BYTE_ZERO;
            p0_d.oe   = `EMB_BYTE_ZERO;
        end else begin
            p0_d.dout = `EMB_BYTE_ZERO;
            p0_d.oe   = rst_s ? `EMB_BYTE_ZERO : ~PORT_LATCH.p0;
        end
        // General port pulls low on zero bits, releases to pullup on ones
        p1_d.dout = `EMB_BYTE_ZERO;
        p1_d.oe   = (rst_s || vfy_s) ? `EMB_BYTE_ZERO : ~PORT_LATCH.p1;
        // High address port
        if (!rst_s && (ext_fetch || (kind_q == KIND_DATA && ptr16_q))) begin
            p2_d.dout = addr_q[15:8];
            p2_d.oe   = `EMB_BYTE_ONES;
        end else begin
            p2_d.dout = `EMB_BYTE_ZERO;
            p2_d.oe   = rst_s ? `EMB_BYTE_ZERO : ~PORT_LATCH.p2;
        end
        // Special port merges latch with serial out and move strobes
        p3_val    = PORT_LATCH.p3;
        p3_val[1] = PORT_LATCH.p3[1] & SERIAL_TX;
        p3_val[6] = PORT_LATCH.p3[6] & ~data_wr;
        p3_val[7] = PORT_LATCH.p3[7] & ~data_rd;
        p3_d.dout = `EMB_BYTE_ZERO;
        p3_d.oe   = rst_s ? `EMB_BYTE_ZERO : ~p3_val;
    end

    // Pin registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            p0_q     <= '0;
            p1_q     <= '0;
            p2_q     <= '0;
            p3_q     <= '0;
            ale_q    <= 1'b0;
            program_store_strobe_n_q <= 1'b1;
            fext_q   <= 1'b0;
        end else begin
            p0_q     <= p0_d;
            p1_q     <= p1_d;
            p2_q     <= p2_d;
            p3_q     <= p3_d;
            ale_q    <= ale_d;
            program_store_strobe_n_q <= program_store_strobe_n_d;
            fext_q   <= fext_d;
        end
    end

    // ---- Capture state ----
    logic [7:0] code_q;
    logic [7:0] code_d;
    logic       code_vld_q;
    logic       code_vld_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       done_q;
    logic       done_d;
    emb_ports_t pins_q;
    emb_ports_t pins_d;
    emb_alt_t   alt_q;
    emb_alt_t   alt_d;
    logic [7:0] vaddr_q;
    logic [7:0] vaddr_d;
    logic       vact_q;
    logic       vact_d;
    logic       rreq_q;
    logic       rreq_d;

    // Sample code and data bytes, mirror pins and alternate inputs
    always_comb begin
        code_d     = code_q;
        rdata_d    = rdata_q;
        // Strobe was low two clocks ago, so the synced byte is valid
        code_vld_d = !rst_s && !program_store_strobe_n_q
                     && (phase == `EMB_PHASE_ZERO || phase == `EMB_HALF_PHASE);
        if (code_vld_d) begin
            code_d = pins_s.p0;
        end
        done_d = !rst_s && (kind_q == KIND_DATA) && (phase == `EMB_RD_SAMPLE);
        if (done_d && !write_q) begin
            rdata_d = pins_s.p0;
        end
        pins_d                = pins_s;
        alt_d.rxd             = pins_s.p3[0];
        alt_d.ext_interrupt_a = pins_s.p3[2];
        alt_d.ext_interrupt_b = pins_s.p3[3];
        alt_d.timer_a_input   = pins_s.p3[4];
        alt_d.timer_b_input   = pins_s.p3[5];
        vaddr_d = vfy_s ? pins_s.p1 : vaddr_q;
        vact_d  = vfy_s;
        rreq_d  = rst_s;
    end

    // Capture registers
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            code_q     <= `EMB_BYTE_ZERO;
            code_vld_q <= 1'b0;
            rdata_q    <= `EMB_BYTE_ZERO;
            done_q     <= 1'b0;
            pins_q     <= '0;
            alt_q      <= '0;
            vaddr_q    <= `EMB_BYTE_ZERO;
            vact_q     <= 1'b0;
            rreq_q     <= 1'b0;
        end else begin
            code_q     <= code_d;
            code_vld_q <= code_vld_d;
            rdata_q    <= rdata_d;
            done_q     <= done_d;
            pins_q     <= pins_d;
            alt_q      <= alt_d;
            vaddr_q    <= vaddr_d;
            vact_q     <= vact_d;
            rreq_q     <= rreq_d;
        end
    end

    // Outputs straight from registers
    assign P0                     = p0_q;
    assign P1                     = p1_q;
    assign P2                     = p2_q;
    assign P3                     = p3_q;
    assign ADDR_LATCH_EN          = ale_q;
    assign PROGRAM_STORE_STROBE_N = program_store_strobe_n_q;
    assign FETCH_EXT              = fext_q;
    assign CODE_BYTE              = code_q;
    assign CODE_VALID             = code_vld_q;
    assign DATA_RDATA             = rdata_q;
    assign DATA_DONE              = done_q;
    assign PORT_PINS              = pins_q;
    assign ALT_IN                 = alt_q;
    assign VERIFY_ADDR            = vaddr_q;
    assign VERIFY_ACTIVE          = vact_q;
    assign RESET_REQ              = rreq_q;

endmodule
`default_nettype wire

// file: emb_mem_model.sv
// Far side of the bus: address latch, program memory and data memory.
// Assumes wire levels of the muxed, high and special ports are given.
`timescale 1ns/1ps
`default_nettype none

module emb_mem_model (
    input  wire logic       clk,
    input  wire logic [7:0] p0_wire,
    input  wire logic [7:0] p2_wire,
    input  wire logic       ale,
    input  wire logic       prog_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       slow,
    output logic            drv_oe,
    output logic      [7:0] drv_d,
    output logic      [7:0] hi_seen
);
    logic [7:0] lo_q;
    logic [7:0] ram [0:255];
    int         wait_cnt;

    // Latch low address as the pulse falls
    always @(negedge ale) begin
        lo_q    <= p0_wire;
        hi_seen <= p2_wire;
    end

    // Data write while strobe low; count read strobe length
    always @(posedge clk) begin
        if (wr_n == 1'b0) begin
            ram[lo_q] <= p0_wire;
        end
        wait_cnt <= rd_n ? 0 : wait_cnt + 1;
    end

    // Code answers at once; data may lag three clocks
    always_comb begin
        drv_oe = 1'b0;
        drv_d  = 8'h00;
        if (prog_n == 1'b0) begin
            drv_oe = 1'b1;
            drv_d  = lo_q ^ p2_wire ^ 8'h3C;
        end else if (rd_n == 1'b0 && (!slow || wait_cnt >= 3)) begin
            drv_oe = 1'b1;
            drv_d  = ram[lo_q];
        end
    end
endmodule

`default_nettype wire

// file: emb_port_ctrl_properties.sv
// Pin timing checker for the external bus port controller.
// Assumes special port latch bits 6 and 7 stay at one.
`timescale 1ns/1ps
`default_nettype none

module emb_port_ctrl_props
    import emb_pkg::*;
(
    input wire logic       CORE_CLK,
    input wire logic       NRST,
    input wire emb_xmove_t XMOVE_REQ,
    input wire emb_ports_t PORT_LATCH,
    input wire emb_pin_t   P0,
    input wire emb_pin_t   P2,
    input wire emb_pin_t   P3,
    input wire logic       ADDR_LATCH_EN,
    input wire logic       PROGRAM_STORE_STROBE_N,
    input wire logic       FETCH_EXT,
    input wire logic       CYCLE_START,
    input wire logic       DATA_DONE,
    input wire logic       RESET_REQ
);
    logic [3:0] hi_q;
    logic [3:0] hi_d;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST || RESET_REQ);

    // Run length of idle program strobe
    always_comb begin
        hi_d = 4'h0;
        if (PROGRAM_STORE_STROBE_N) begin
            hi_d = (hi_q == 4'hF) ? hi_q : hi_q + 4'h1;
        end
    end
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            hi_q <= 4'h0;
        end else begin
            hi_q <= hi_d;
        end
    end

    // Pulse tails
    sequence s_ale_tail;
        ADDR_LATCH_EN ##1 !ADDR_LATCH_EN;
    endsequence
    sequence s_strobe_tail;
        !PROGRAM_STORE_STROBE_N [*2] ##1 PROGRAM_STORE_STROBE_N;
    endsequence

    a_ale_width: assert property ($rose(ADDR_LATCH_EN) |=> s_ale_tail)
        else $error("latch pulse width wrong");
    a_ale_rate: assert property ($rose(ADDR_LATCH_EN) |->
        (##6 $rose(ADDR_LATCH_EN)) or (##12 $rose(ADDR_LATCH_EN)))
        else $error("latch pulse spacing wrong");
    a_ale_skip: assert property (DATA_DONE |-> $past(ADDR_LATCH_EN, 10) &&
        !$past(ADDR_LATCH_EN, 5) && !$past(ADDR_LATCH_EN, 4))
        else $error("data cycle latch pulses wrong");
    a_strobe_width: assert property ($fell(PROGRAM_STORE_STROBE_N) |=> s_strobe_tail)
        else $error("program strobe width wrong");
    a_strobe_ext: assert property ($fell(PROGRAM_STORE_STROBE_N) |->
        FETCH_EXT && P2.oe == 8'hFF)
        else $error("program strobe outside external fetch");
    a_strobe_skip: assert property (DATA_DONE |-> hi_q >= 4'h8)
        else $error("program strobe during data move");
    a_bus_drive: assert property ($fell(PROGRAM_STORE_STROBE_N) |->
        $past(P0.oe, 2) == 8'hFF && P0.oe == 8'h00)
        else $error("muxed port drive wrong");
    a_reset_quiet: assert property (disable iff (!NRST)
        RESET_REQ && $past(RESET_REQ) |-> !ADDR_LATCH_EN && PROGRAM_STORE_STROBE_N &&
        P0.oe == 8'h00 && !CYCLE_START)
        else $error("outputs active in reset");
    a_move_strobe: assert property (DATA_DONE |-> $past(P3.dout[7:6]) == 2'b00 &&
        $past(P3.oe[7:6]) == ($past(XMOVE_REQ.write) ? 2'b01 : 2'b10))
        else $error("data strobe pin wrong");
    a_high_byte: assert property (DATA_DONE |-> $past(P2.oe) ==
        ($past(XMOVE_REQ.ptr16) ? 8'hFF : ~$past(PORT_LATCH.p2)))
        else $error("high port during move wrong");
endmodule

bind emb_port_ctrl emb_port_ctrl_props u_props (
    .CORE_CLK              (CORE_CLK),
    .NRST                  (NRST),
    .XMOVE_REQ             (XMOVE_REQ),
    .PORT_LATCH            (PORT_LATCH),
    .P0                    (P0),
    .P2                    (P2),
    .P3                    (P3),
    .ADDR_LATCH_EN         (ADDR_LATCH_EN),
    .PROGRAM_STORE_STROBE_N(PROGRAM_STORE_STROBE_N),
    .FETCH_EXT             (FETCH_EXT),
    .CYCLE_START           (CYCLE_START),
    .DATA_DONE             (DATA_DONE),
    .RESET_REQ             (RESET_REQ)
);

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the external bus port controller.
// Assumes emb_mem_model stands on the bus and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_top
    import emb_pkg::*;
();
    logic        clk = 1'b0;
    logic        nrst;
    logic [15:0] fetch_addr;
    emb_xmove_t  xreq;
    emb_ports_t  latch;
    emb_ports_t  pin_in;
    logic        tx;
    logic        rst_pin;
    logic        verify;
    logic        ea_n;
    logic        slow;
    logic [7:0]  ext_p1;
    logic [7:0]  ext_p3;
    logic [7:0]  fill = 8'h5A;
    logic [7:0]  rom;
    emb_pin_t    p0;
    emb_pin_t    p1;
    emb_pin_t    p2;
    emb_pin_t    p3;
    logic        ale;
    logic        program_store_strobe_n;
    logic        cstart;
    logic        fext;
    logic [7:0]  code_b;
    logic        code_v;
    logic [7:0]  rdata;
    logic        done;
    emb_ports_t  pins;
    emb_alt_t    alt;
    logic [7:0]  vaddr;
    logic        vact;
    logic        rreq;
    logic        m_oe;
    logic [7:0]  m_d;
    logic [7:0]  hi_seen;
    int          bad_count = 0;
    int          total_checks = 0;

    always #5 clk = ~clk;
    // Released muxed lines show a changing pattern
    always @(posedge clk) fill <= ~fill;

    // Wire levels: driven bits, else far side, pullups or external pulls
    assign pin_in.p0 = (p0.oe & p0.dout) | (~p0.oe & (m_oe ? m_d : fill));
    assign pin_in.p1 = (p1.oe & p1.dout) | (~p1.oe & ext_p1);
    assign pin_in.p2 = (p2.oe & p2.dout) | ~p2.oe;
    assign pin_in.p3 = (p3.oe & p3.dout) | (~p3.oe & ext_p3);
    assign rom = vaddr ^ 8'h77;

    emb_port_ctrl uut (
        .CORE_CLK(clk), .NRST(nrst), .FETCH_ADDR(fetch_addr), .XMOVE_REQ(xreq),
        .PORT_LATCH(latch), .SERIAL_TX(tx), .ROM_DATA(rom), .PORT_IN(pin_in),
        .EXT_ACCESS_SELECT_N(ea_n), .RST_PIN(rst_pin), .VERIFY_PIN(verify),
        .P0(p0), .P1(p1), .P2(p2), .P3(p3), .ADDR_LATCH_EN(ale),
        .PROGRAM_STORE_STROBE_N(program_store_strobe_n), .CYCLE_START(cstart), .FETCH_EXT(fext),
        .CODE_BYTE(code_b), .CODE_VALID(code_v), .DATA_RDATA(rdata), .DATA_DONE(done),
        .PORT_PINS(pins), .ALT_IN(alt), .VERIFY_ADDR(vaddr), .VERIFY_ACTIVE(vact),
        .RESET_REQ(rreq)
    );

    emb_mem_model u_mem (
        .clk(clk), .p0_wire(pin_in.p0), .p2_wire(pin_in.p2), .ale(ale),
        .prog_n(program_store_strobe_n), .rd_n(pin_in.p3[7]), .wr_n(pin_in.p3[6]), .slow(slow),
        .drv_oe(m_oe), .drv_d(m_d), .hi_seen(hi_seen)
    );

    // Step n clocks, land just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Verdict and stop
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset pin quiets the bus, then cycles resume
    task automatic t_reset_pin;
        int n = 0;
        rst_pin = 1'b1;
        tick(6);
        `CHK("reset_req", 1'b1, rreq)
        repeat (12) begin
            tick(1);
            n += int'(cstart !== 1'b0 || ale !== 1'b0);
        end
        `CHK("reset_quiet", 0, n)
        rst_pin = 1'b0;
        n = 0;
        while (cstart !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        `CHK("restart", 1'b1, cstart)
    endtask

    // Count pulses over eight machine halves for one fetch setting
    task automatic t_fetch(input logic ea, input logic [15:0] a, input int ext);
        int   na = 0;
        int   ns = 0;
        int   nv = 0;
        logic pa;
        logic ps;
        ea_n = ea;
        fetch_addr = a;
        tick(24);
        pa = ale;
        ps = program_store_strobe_n;
        repeat (48) begin
            tick(1);
            na += int'(ale & ~pa);
            ns += int'(~program_store_strobe_n & ps);
            nv += int'(code_v);
            pa = ale;
            ps = program_store_strobe_n;
        end
        `CHK("ale_count", 8, na)
        `CHK("strobe_count", ext * 8, ns)
        `CHK("code_count", ext * 8, nv)
        if (ext == 1) `CHK("code_byte", a[7:0] ^ a[15:8] ^ 8'h3C, code_b)
        else `CHK("port0_float", 8'h00, p0.oe)
    endtask

    // Hold one data move until its completion pulse
    task automatic do_move(input logic w, input logic p16, input logic [15:0] a,
                           input logic [7:0] d);
        int n = 0;
        xreq = {1'b1, w, p16, a, d};
        // Taken at the cycle boundary; drop valid so it is not taken twice
        do begin
            tick(1);
            n++;
        end while (cstart !== 1'b1 && n < 14);
        xreq.valid = 1'b0;
        do begin
            tick(1);
            n++;
        end while (done !== 1'b1 && n < 40);
        `CHK("move_done", 1'b1, done)
    endtask

    // Wide write then narrow slow read, one fetch cycle apart
    task automatic t_moves;
        ea_n = 1'b0;
        fetch_addr = 16'h0000;
        tick(24);
        do_move(1'b1, 1'b1, 16'h12A5, 8'h5C);
        `CHK("high_byte", 8'h12, hi_seen)
        slow = 1'b1;
        do_move(1'b0, 1'b0, 16'h77A5, 8'h00);
        `CHK("read_data", 8'h5C, rdata)
        `CHK("high_port", 8'h3C, hi_seen)
        xreq.valid = 1'b0;
        slow = 1'b0;
        tick(24);
    endtask

    // General and special port inputs and alternate functions
    task automatic t_ports;
        ea_n = 1'b1;
        fetch_addr = 16'h0100;
        tx = 1'b0;
        ext_p1 = 8'h96;
        ext_p3 = 8'hC7;
        latch.p1 = 8'h0F;
        tick(24);
        `CHK("port1_low", 8'h06, pins.p1)
        `CHK("alt_in", 5'b00011, alt)
        `CHK("tx_pin", 1'b0, pin_in.p3[1])
        latch.p1 = 8'hFF;
        tx = 1'b1;
        tick(24);
        `CHK("port1_in", 8'h96, pins.p1)
    endtask

    // Verify mode: address in on port 1, code byte out on port 0
    task automatic t_verify;
        verify = 1'b1;
        ext_p1 = 8'h4B;
        tick(24);
        `CHK("verify_on", 1'b1, vact)
        `CHK("verify_addr", 8'h4B, vaddr)
        `CHK("verify_oe", 8'hFF, p0.oe)
        `CHK("verify_byte", 8'h3C, p0.dout)
        verify = 1'b0;
        tick(8);
    endtask

    // Main sequence
    initial begin
        nrst = 1'b0;
        fetch_addr = 16'h0000;
        xreq = '0;
        latch = {8'hFF, 8'h3C, 8'hFF, 8'hFF};
        tx = 1'b1;
        rst_pin = 1'b0;
        verify = 1'b0;
        ea_n = 1'b1;
        slow = 1'b0;
        ext_p1 = 8'hFF;
        ext_p3 = 8'hFF;
        tick(12);
        nrst = 1'b1;
        tick(4);
        t_reset_pin();
        t_fetch(1'b1, 16'h0100, 0);
        t_fetch(1'b1, 16'h0FFF, 0);
        t_fetch(1'b1, 16'h1000, 1);
        t_fetch(1'b0, 16'h0000, 1);
        t_fetch(1'b0, 16'h0FFF, 1);
        t_moves();
        t_ports();
        t_verify();
        end_sim();
    end

    // Watchdog
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
endmodule

`default_nettype wire
